/* hw/hlc_pkg.sv */
// Constants shared by the haptic loop control front end
package hlc_pkg;
  localparam int CLK_HZ = 25_000_000;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_MODE   = 6'h01;
  localparam logic [5:0] IDX_PLAY   = 6'h02;
  localparam logic [5:0] IDX_GO     = 6'h0c;
  localparam logic [5:0] IDX_RATED  = 6'h16;
  localparam logic [5:0] IDX_OD     = 6'h17;
  localparam logic [5:0] IDX_CCOMP  = 6'h18;
  localparam logic [5:0] IDX_CBEMF  = 6'h19;
  localparam logic [5:0] IDX_FB     = 6'h1a;
  localparam logic [5:0] IDX_CTRL1  = 6'h1b;
  localparam logic [5:0] IDX_CTRL2  = 6'h1c;
  localparam logic [5:0] IDX_CTRL3  = 6'h1d;
  localparam logic [5:0] IDX_CTRL4  = 6'h1e;
  localparam logic [5:0] IDX_OLPER  = 6'h20;
  // Field positions
  localparam int ST_BUSY      = 0;
  localparam int ST_DIAG_FAIL = 3;
  localparam int MODE_LSB     = 0;
  localparam int STANDBY_BIT  = 6;
  localparam int FB_RESONANT  = 7;
  localparam int FB_BRAKE_LSB = 4;
  localparam int FB_LOOP_LSB  = 2;
  localparam int FB_BGAIN_LSB = 0;
  localparam int BOOST_BIT    = 7;
  localparam int STAB_BIT     = 6;
  localparam int SAMPLE_LSB   = 4;
  localparam int MASS_OL_BIT  = 5;
  localparam int TWICE_BIT    = 2;
  localparam int RES_OL_BIT   = 0;
  localparam int CALTIME_LSB  = 4;
  // Reset values
  localparam logic [7:0] MODE_RST  = 8'h40;
  localparam logic [7:0] RATED_RST = 8'h3f;
  localparam logic [7:0] OD_RST    = 8'h8c;
  localparam logic [7:0] CCOMP_RST = 8'h0d;
  localparam logic [7:0] CBEMF_RST = 8'h6d;
  localparam logic [7:0] FB_RST    = 8'h36;
  localparam logic [7:0] CTRL1_RST = 8'h80;
  localparam logic [7:0] CTRL2_RST = 8'h70;
  localparam logic [7:0] CTRL4_RST = 8'h20;
  localparam logic [6:0] OLPER_RST = 7'h33;
  // Interface modes
  localparam logic [2:0] MODE_PLAY = 3'h5;
  localparam logic [2:0] MODE_PWM  = 3'h3;
  localparam logic [2:0] MODE_DIAG = 3'h6;
  localparam logic [2:0] MODE_CAL  = 3'h7;
  // Timing
  localparam int OL_UNIT_NS  = 98_490;
  localparam int OL_UNIT_CYC = int'((longint'(OL_UNIT_NS) * CLK_HZ) / 1_000_000_000);
  localparam int CAL_BASE_MS = 150;
  localparam int CAL_BASE_CYC = CAL_BASE_MS * (CLK_HZ / 1000);
  localparam logic [15:0] PWM_TIMEOUT = 16'hffff;
  localparam int OL_PWM_DIV = 128;
  localparam logic [3:0] BOOST_PERIODS = 4'h8;
  // Analog decision levels and AXI response codes
  localparam logic [7:0] SHORT_LIMIT = 8'h08;
  localparam logic [7:0] OPEN_LIMIT  = 8'hf0;
  localparam logic [7:0] MOVE_LIMIT  = 8'h10;
  localparam logic [7:0] BEMF_MIN    = 8'h04;
  localparam logic [9:0] BRAKE_NEAR  = 10'h008;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    HLC_IDLE = 3'b001,
    HLC_CAL  = 3'b010,
    HLC_DIAG = 3'b100
  } hlc_state_t;
endpackage

/* hw/hlc_pwm_if.sv */
// Measured PWM input passed from the meter to the control loop
`timescale 1ns/1ps
interface hlc_pwm_if;
  logic [7:0] duty;
  logic       duty_stb;
  logic       ol_pol;
  modport src (output duty, output duty_stb, output ol_pol);
  modport snk (input duty, input duty_stb, input ol_pol);
endinterface

/* hw/hlc_pwm_meas.sv */
// PWM input duty meter and fixed divide-by-128 commutation
`timescale 1ns/1ps
module hlc_pwm_meas (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  pwm_pin,
  hlc_pwm_if.src     m
);
  logic        pin_q;
  logic        per_ok;
  logic [15:0] per_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] div_per;
  logic [16:0] rem;
  logic [16:0] rem2;
  logic [3:0]  div_n;
  logic [7:0]  quo;
  logic [5:0]  edge_cnt;
  logic        rise;

  assign rise = pwm_pin & ~pin_q;
  assign rem2 = {rem[15:0], 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q    <= 1'b0;
      per_ok   <= 1'b0;
      per_cnt  <= 16'h0000;
      hi_cnt   <= 16'h0000;
    end else begin
      pin_q <= pwm_pin;
      if (rise) begin
        per_cnt <= 16'h0001;
        hi_cnt  <= 16'h0001;
        per_ok  <= 1'b1;
      end else if (per_cnt == hlc_pkg::PWM_TIMEOUT) begin
        // A stuck pin restarts the count so the loop still sees 0 or 100 percent
        per_cnt <= 16'h0001;
        hi_cnt  <= 16'h0000;
        per_ok  <= 1'b0;
      end else begin
        per_cnt <= per_cnt + 16'h0001;
        hi_cnt  <= hi_cnt + {15'h0000, pwm_pin};
      end
    end
  end

  // Serial divide of high time by period, one quotient bit a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_n      <= 4'h0;
      div_per    <= 16'h0001;
      rem        <= 17'h00000;
      quo        <= 8'h00;
      m.duty     <= 8'h00;
      m.duty_stb <= 1'b0;
    end else begin
      m.duty_stb <= 1'b0;
      if (rise && per_ok) begin
        rem     <= {1'b0, hi_cnt};
        div_per <= per_cnt;
        div_n   <= 4'h8;
      end else if (per_cnt == hlc_pkg::PWM_TIMEOUT) begin
        m.duty     <= pwm_pin ? 8'hff : 8'h00;
        m.duty_stb <= 1'b1;
      end else if (div_n != 4'h0) begin
        div_n <= div_n - 4'h1;
        if (rem2 >= {1'b0, div_per}) begin
          rem <= rem2 - {1'b0, div_per};
          quo <= {quo[6:0], 1'b1};
        end else begin
          rem <= rem2;
          quo <= {quo[6:0], 1'b0};
        end
        if (div_n == 4'h1) begin
          m.duty     <= {quo[6:0], rem2 >= {1'b0, div_per}};
          m.duty_stb <= 1'b1;
        end
      end
    end
  end

  // Drive polarity flips every 64 input periods, one drive period per 128
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_cnt <= 6'h00;
      m.ol_pol <= 1'b0;
    end else if (rise) begin
      edge_cnt <= edge_cnt + 6'h01;
      if (edge_cnt == 6'(hlc_pkg::OL_PWM_DIV / 2 - 1)) begin
        m.ol_pol <= ~m.ol_pol;
      end
    end
  end
endmodule

/* hw/hlc_top.sv */
// Haptic loop control and PWM front end with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module hlc_top #(
  parameter int CAL_BASE_CYCLES = hlc_pkg::CAL_BASE_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  input  wire logic       input_trigger_pin,
  input  wire logic [7:0] backemf_level,
  input  wire logic       backemf_sign,
  input  wire logic [7:0] impedance_code,
  output logic            drive_en,
  output logic [7:0]      drive_level,
  output logic            drive_polarity,
  output logic            backemf_sample,
  output logic [2:0]      backemf_gain_eff
);
  logic [5:0]  aw_idx;
  logic [7:0]  w_byte;
  logic        w_lane;
  logic        wr_fire;
  logic        wr_en;
  logic [7:0]  mode_reg;
  logic [7:0]  play_reg;
  logic [7:0]  rated_reg;
  logic [7:0]  overdrive_limit;
  logic [7:0]  cal_comp;
  logic [7:0]  backemf_norm_factor;
  logic [7:0]  fb_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic [7:0]  ctrl3_reg;
  logic [7:0]  ctrl4_reg;
  logic [6:0]  open_loop_period;
  logic        go;
  logic        diagnostic_fail_flag;
  logic        cal_done;
  logic [31:0] run_cnt;
  logic [31:0] run_len;
  logic [7:0]  rd_val;
  hlc_pkg::hlc_state_t state;
  logic [2:0]  mode;
  logic        standby;
  logic        resonant;
  logic        resonant_open_loop_en;
  logic        twice_per_period_sampling;
  logic [2:0]  brake_gain_ratio;
  logic [1:0]  loop_gain;
  logic [1:0]  backemf_amp_gain;
  logic        running;
  logic        run_q;
  logic        start;
  logic        upd;
  logic [3:0]  boost_cnt;
  logic        base_pol;
  logic        base_pol_q;
  logic [19:0] ol_cnt;
  logic [7:0]  next_level;
  logic        next_rev;
  logic [1:0]  next_bgain;

  hlc_pwm_if pwm ();

  hlc_pwm_meas u_meas (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pwm_pin (input_trigger_pin),
    .m       (pwm.src)
  );

  function automatic logic hlc_known(input logic [5:0] idx);
    unique case (idx)
      hlc_pkg::IDX_STATUS, hlc_pkg::IDX_MODE, hlc_pkg::IDX_PLAY, hlc_pkg::IDX_GO,
      hlc_pkg::IDX_RATED, hlc_pkg::IDX_OD, hlc_pkg::IDX_CCOMP, hlc_pkg::IDX_CBEMF,
      hlc_pkg::IDX_FB, hlc_pkg::IDX_CTRL1, hlc_pkg::IDX_CTRL2, hlc_pkg::IDX_CTRL3,
      hlc_pkg::IDX_CTRL4, hlc_pkg::IDX_OLPER: hlc_known = 1'b1;
      default: hlc_known = 1'b0;
    endcase
  endfunction

  assign mode                      = mode_reg[hlc_pkg::MODE_LSB +: 3];
  assign standby                   = mode_reg[hlc_pkg::STANDBY_BIT];
  assign resonant                  = fb_reg[hlc_pkg::FB_RESONANT];
  assign brake_gain_ratio          = fb_reg[hlc_pkg::FB_BRAKE_LSB +: 3];
  assign loop_gain                 = fb_reg[hlc_pkg::FB_LOOP_LSB +: 2];
  assign backemf_amp_gain          = fb_reg[hlc_pkg::FB_BGAIN_LSB +: 2];
  assign resonant_open_loop_en     = ctrl3_reg[hlc_pkg::RES_OL_BIT];
  assign twice_per_period_sampling = ctrl3_reg[hlc_pkg::TWICE_BIT];
  assign wr_fire = !awready && !wready && !bvalid;
  assign wr_en   = wr_fire && w_lane && hlc_known(aw_idx);

  // Address and data are held separately so the master may send them in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= hlc_pkg::RESP_OKAY;
      aw_idx  <= 6'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_idx  <= awaddr[7:2];
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= hlc_known(aw_idx) ? hlc_pkg::RESP_OKAY : hlc_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (araddr[7:2])
      hlc_pkg::IDX_STATUS: rd_val = {4'h0, diagnostic_fail_flag, 2'h0, !state[0]};
      hlc_pkg::IDX_MODE:   rd_val = mode_reg;
      hlc_pkg::IDX_PLAY:   rd_val = play_reg;
      hlc_pkg::IDX_GO:     rd_val = {7'h00, go};
      hlc_pkg::IDX_RATED:  rd_val = rated_reg;
      hlc_pkg::IDX_OD:     rd_val = overdrive_limit;
      hlc_pkg::IDX_CCOMP:  rd_val = cal_comp;
      hlc_pkg::IDX_CBEMF:  rd_val = backemf_norm_factor;
      hlc_pkg::IDX_FB:     rd_val = fb_reg;
      hlc_pkg::IDX_CTRL1:  rd_val = ctrl1_reg;
      hlc_pkg::IDX_CTRL2:  rd_val = ctrl2_reg;
      hlc_pkg::IDX_CTRL3:  rd_val = ctrl3_reg;
      hlc_pkg::IDX_CTRL4:  rd_val = ctrl4_reg;
      hlc_pkg::IDX_OLPER:  rd_val = {1'b0, open_loop_period};
      default:             rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= hlc_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h00_0000, rd_val};
        rresp   <= hlc_known(araddr[7:2]) ? hlc_pkg::RESP_OKAY : hlc_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Calibration results land after any software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg            <= hlc_pkg::MODE_RST;
      play_reg            <= 8'h00;
      rated_reg           <= hlc_pkg::RATED_RST;
      overdrive_limit     <= hlc_pkg::OD_RST;
      cal_comp            <= hlc_pkg::CCOMP_RST;
      backemf_norm_factor <= hlc_pkg::CBEMF_RST;
      fb_reg              <= hlc_pkg::FB_RST;
      ctrl1_reg           <= hlc_pkg::CTRL1_RST;
      ctrl2_reg           <= hlc_pkg::CTRL2_RST;
      ctrl3_reg           <= 8'h00;
      ctrl4_reg           <= hlc_pkg::CTRL4_RST;
      open_loop_period    <= hlc_pkg::OLPER_RST;
    end else begin
      if (wr_en) begin
        unique case (aw_idx)
          hlc_pkg::IDX_MODE:  mode_reg <= w_byte;
          hlc_pkg::IDX_PLAY:  play_reg <= w_byte;
          hlc_pkg::IDX_RATED: rated_reg <= w_byte;
          hlc_pkg::IDX_OD:    overdrive_limit <= w_byte;
          hlc_pkg::IDX_CCOMP: cal_comp <= w_byte;
          hlc_pkg::IDX_CBEMF: backemf_norm_factor <= w_byte;
          hlc_pkg::IDX_FB:    fb_reg <= w_byte;
          hlc_pkg::IDX_CTRL1: ctrl1_reg <= w_byte;
          hlc_pkg::IDX_CTRL2: ctrl2_reg <= w_byte;
          hlc_pkg::IDX_CTRL3: ctrl3_reg <= w_byte;
          hlc_pkg::IDX_CTRL4: ctrl4_reg <= w_byte;
          hlc_pkg::IDX_OLPER: open_loop_period <= w_byte[6:0];
          default: ;
        endcase
      end
      if (cal_done) begin
        cal_comp            <= impedance_code;
        backemf_norm_factor <= 8'hff - backemf_level;
        fb_reg[hlc_pkg::FB_BGAIN_LSB +: 2] <= next_bgain;
      end
    end
  end

  // Weaker back-EMF asks for more amplifier gain
  always_comb begin
    if (backemf_level < 8'h20) begin
      next_bgain = 2'h3;
    end else if (backemf_level < 8'h40) begin
      next_bgain = 2'h2;
    end else if (backemf_level < 8'h80) begin
      next_bgain = 2'h1;
    end else begin
      next_bgain = 2'h0;
    end
  end

  assign run_len = CAL_BASE_CYCLES * (32'(ctrl4_reg[hlc_pkg::CALTIME_LSB +: 2]) + 32'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                <= hlc_pkg::HLC_IDLE;
      go                   <= 1'b0;
      run_cnt              <= 32'h0;
      cal_done             <= 1'b0;
      diagnostic_fail_flag <= 1'b0;
    end else begin
      cal_done <= 1'b0;
      unique case (state)
        hlc_pkg::HLC_IDLE: begin
          run_cnt <= 32'h0;
          if (go && !standby && (mode == hlc_pkg::MODE_CAL || mode == hlc_pkg::MODE_DIAG)) begin
            diagnostic_fail_flag <= 1'b0;
            state <= (mode == hlc_pkg::MODE_CAL) ? hlc_pkg::HLC_CAL : hlc_pkg::HLC_DIAG;
          end
        end
        hlc_pkg::HLC_CAL: begin
          run_cnt <= run_cnt + 32'h1;
          if (!go) begin
            state <= hlc_pkg::HLC_IDLE;
          end else if (run_cnt >= run_len - 32'h1) begin
            state <= hlc_pkg::HLC_IDLE;
            go    <= 1'b0;
            if (backemf_level < hlc_pkg::BEMF_MIN || impedance_code < hlc_pkg::SHORT_LIMIT ||
                impedance_code > hlc_pkg::OPEN_LIMIT) begin
              diagnostic_fail_flag <= 1'b1;
            end else begin
              cal_done <= 1'b1;
            end
          end
        end
        hlc_pkg::HLC_DIAG: begin
          run_cnt <= run_cnt + 32'h1;
          if (!go) begin
            state <= hlc_pkg::HLC_IDLE;
          end else if (run_cnt >= 32'(CAL_BASE_CYCLES) - 32'h1) begin
            state <= hlc_pkg::HLC_IDLE;
            go    <= 1'b0;
            if (impedance_code < hlc_pkg::SHORT_LIMIT ||
                impedance_code > hlc_pkg::OPEN_LIMIT) begin
              diagnostic_fail_flag <= 1'b1;
            end
          end
        end
      endcase
      // A software write lands over the end-of-run clear, so a new start is not lost
      if (wr_en && aw_idx == hlc_pkg::IDX_GO) begin
        go <= w_byte[0];
      end
    end
  end

  // Continuous modes run until standby or another mode is chosen
  assign running = !standby && (mode == hlc_pkg::MODE_PWM || mode == hlc_pkg::MODE_PLAY ||
                   state == hlc_pkg::HLC_CAL);
  assign start = running && !run_q;
  assign upd   = (mode == hlc_pkg::MODE_PWM) ? pwm.duty_stb : 1'b1;

  always_comb begin
    logic [7:0]  duty;
    logic [15:0] tgt_p;
    logic [15:0] fb_p;
    logic [7:0]  fbk;
    logic [9:0]  err;
    logic [6:0]  k;
    logic [15:0] corr;
    logic [15:0] sum;
    logic [15:0] mag;
    logic [15:0] od_p;
    duty = 8'h00;
    tgt_p = 16'h0;
    fb_p = 16'h0;
    fbk = 8'h00;
    err = 10'h0;
    k = 7'h0;
    corr = 16'h0;
    sum = 16'h0;
    mag = 16'h0;
    od_p = 16'h0;
    if (state == hlc_pkg::HLC_CAL) begin
      duty = 8'hff;
    end else if (mode == hlc_pkg::MODE_PWM) begin
      duty = pwm.duty;
    end else begin
      duty = play_reg;
    end
    tgt_p = duty * rated_reg;
    od_p  = duty * overdrive_limit;
    fb_p  = backemf_level * backemf_norm_factor;
    fbk   = fb_p[15] ? 8'hff : fb_p[14:7];
    err   = {2'b00, tgt_p[15:8]} - {2'b00, fbk};
    k     = 7'(loop_gain) + 7'h1;
    if (ctrl1_reg[hlc_pkg::BOOST_BIT] && boost_cnt != 4'h0) begin
      k = k + 7'h2;
    end
    if (err[9]) begin
      k = 7'(k * (7'(brake_gain_ratio) + 7'h1));
      if (ctrl2_reg[hlc_pkg::STAB_BIT] && (10'h000 - err) < hlc_pkg::BRAKE_NEAR) begin
        k = 7'h1;
      end
    end
    corr = 16'($signed(err) * $signed({1'b0, k})) >>> 2;
    corr = {{2{corr[15]}}, corr[15:2]};
    sum  = {8'h00, tgt_p[15:8]} + corr;
    mag  = sum[15] ? 16'h0 - sum : sum;
    next_rev = sum[15];
    if (!resonant && ctrl3_reg[hlc_pkg::MASS_OL_BIT]) begin
      next_level = od_p[15:8];
      next_rev   = 1'b0;
    end else if (resonant && resonant_open_loop_en) begin
      next_level = tgt_p[15:8];
      next_rev   = 1'b0;
    end else if (mag > {8'h00, overdrive_limit}) begin
      next_level = overdrive_limit;
    end else begin
      next_level = mag[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q     <= 1'b0;
      boost_cnt <= 4'h0;
    end else begin
      run_q <= running;
      if (start) begin
        boost_cnt <= hlc_pkg::BOOST_PERIODS;
      end else if (upd && pwm.duty_stb && boost_cnt != 4'h0) begin
        boost_cnt <= boost_cnt - 4'h1;
      end
    end
  end

  // Resonant phase: PWM divider, digital period timer or back-EMF tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_pol <= 1'b0;
      ol_cnt   <= 20'h0;
    end else if (!running || !resonant) begin
      base_pol <= 1'b0;
      ol_cnt   <= 20'h0;
    end else if (start) begin
      base_pol <= (backemf_level > hlc_pkg::MOVE_LIMIT) ? backemf_sign : 1'b0;
      ol_cnt   <= 20'h0;
    end else if (resonant_open_loop_en && mode == hlc_pkg::MODE_PWM) begin
      base_pol <= pwm.ol_pol;
    end else if (resonant_open_loop_en) begin
      if (ol_cnt + 20'h1 >= 20'(open_loop_period * hlc_pkg::OL_UNIT_CYC / 2)) begin
        ol_cnt   <= 20'h0;
        base_pol <= ~base_pol;
      end else begin
        ol_cnt <= ol_cnt + 20'h1;
      end
    end else if (backemf_level > hlc_pkg::MOVE_LIMIT) begin
      base_pol <= backemf_sign;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_en         <= 1'b0;
      drive_level      <= 8'h00;
      drive_polarity   <= 1'b0;
      backemf_sample   <= 1'b0;
      backemf_gain_eff <= 3'h0;
      base_pol_q       <= 1'b0;
    end else begin
      base_pol_q       <= base_pol;
      drive_en         <= running;
      backemf_gain_eff <= 3'(backemf_amp_gain) + 3'(ctrl2_reg[hlc_pkg::SAMPLE_LSB +: 2]);
      backemf_sample   <= (base_pol && !base_pol_q) ||
                          (twice_per_period_sampling && !base_pol && base_pol_q);
      if (!running) begin
        drive_level    <= 8'h00;
        drive_polarity <= 1'b0;
      end else if (upd) begin
        drive_level    <= next_level;
        drive_polarity <= base_pol ^ next_rev;
      end
    end
  end
endmodule

/* dv/hlc_host_pwm.sv */
// Host-side PWM source driving the input pin
`timescale 1ns/1ps
module hlc_host_pwm (
  input  wire logic       aclk,
  input  wire logic [7:0] high,
  input  wire logic [7:0] period,
  output logic            pin
);
  logic [7:0] cnt = 8'h0;
  // Host sets period to 1/128 of the wanted drive period
  always_ff @(posedge aclk) begin
    cnt <= (cnt + 8'h1 >= period) ? 8'h0 : cnt + 8'h1;
    pin <= (cnt < high);
  end
endmodule

/* dv/hlc_props.sv */
// Port assertions for the loop control front end
`timescale 1ns/1ps
module hlc_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic        backemf_sample,
  input wire logic [2:0]  backemf_gain_eff
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  AST_WR_RESP: assert property (s_wr |-> ##2 bvalid) else $error("no write answer");
  AST_WR_HOLD: assert property (s_wr |=> (!awready && !wready)[*2]) else $error("ready early");
  AST_RD_RESP: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
  AST_RD_HOLD: assert property (arvalid && arready |=> !arready) else $error("arready early");
  AST_RD_HIGH: assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("rdata upper");
  AST_BRESP: assert property (bvalid |-> !bresp[0]) else $error("bad bresp");
  AST_SAMPLE: assert property ($rose(backemf_sample) |=> !backemf_sample)
    else $error("long sample");
  AST_GAIN: assert property (backemf_gain_eff != 3'h7)
    else $error("gain range");
endmodule

/* dv/testbench.sv */
// Self-checking bench for the loop control front end
`timescale 1ns/1ps
module testbench;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 1, rready = 1, backemf_sign = 0, input_trigger_pin;
  logic        awready, wready, bvalid, arready, rvalid, drive_en, drive_polarity, backemf_sample;
  logic [7:0]  awaddr = 0, araddr = 0, backemf_level = 8'h40, impedance_code = 8'h40;
  logic [7:0]  hi = 8'h06, per = 8'h0c, drive_level;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  logic [2:0]  backemf_gain_eff;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, seed = 3518;
  int          ix[4] = '{1, 'h17, 'h1a, 'h20};
  int          rv[4] = '{'h40, 'h8c, 'h36, 'h33};
  hlc_top #(.CAL_BASE_CYCLES(20)) dut (.*);
  hlc_host_pwm host (.aclk(aclk), .high(hi), .period(per), .pin(input_trigger_pin));
  initial forever #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, output logic [1:0] r);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Run should need under 10000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          v, n;
    logic        p, pl;
    int          mq[$];
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ix[k]) begin
      rd(ix[k][5:0], d, r);
      chk(d, rv[k]);
    end
    chk(backemf_gain_eff, 2 + 3);
    repeat (4) begin
      v = $random(seed);
      wr(6'h17, v[7:0], r);
      wr(6'h20, v[15:8], r);
      mq.push_back(v[7:0]);
      mq.push_back(v[14:8]);
      rd(6'h17, d, r);
      chk(d, mq.pop_front());
      rd(6'h20, d, r);
      chk(d, mq.pop_front());
    end
    wr(6'h3f, 8'h5a, r);
    chk(r, 2'h2);
    rd(6'h3f, d, r);
    chk(d, 0);
    chk(r, 2'h2);
    $display("register test done");
    wr(6'h1e, 8'h30, r);
    for (int c = 0; c < 3; c++) begin
      v = $random(seed);
      impedance_code <= (c == 0) ? 8'h10 + v[6:0] : (c == 1 ? 8'h02 : 8'hf8);
      backemf_level <= 8'h08 + v[13:8];
      wr(6'h01, (c == 2) ? 8'h06 : 8'h07, r);
      wr(6'h0c, 8'h01, r);
      n = 0;
      do begin
        rd(6'h00, d, r);
        n++;
      end while (d[0]);
      chk(d[3], c != 0);
      // Four base lengths of 20 cycles, two cycles per status poll
      if (c < 2) chk(n > 34 && n < 44, 1);
      if (c == 0) begin
        rd(6'h18, d, r);
        chk(d, impedance_code);
        rd(6'h19, d, r);
        chk(d, 8'hff - backemf_level);
        rd(6'h1a, d, r);
        chk(d[7:2], 6'h0d);
      end
    end
    $display("calibration test done");
    v = $random(seed);
    hi <= 8'h01 + v[4:0];
    per <= 8'h28;
    wr(6'h17, 8'hc0, r);
    wr(6'h1d, 8'h20, r);
    wr(6'h1a, 8'h36, r);
    wr(6'h01, 8'h03, r);
    repeat (200) @(posedge aclk);
    chk(drive_en, 1);
    chk(drive_level != 0 && drive_level <= 8'hc0, 1);
    chk(drive_level, (hi * 256 / per) * 8'hc0 / 256);
    wr(6'h01, 8'h43, r);
    repeat (4) @(posedge aclk);
    chk(drive_en, 0);
    $display("pwm test done");
    per <= 8'h0c;
    hi <= 8'h06;
    wr(6'h1a, 8'hb6, r);
    for (int t = 0; t < 2; t++) begin
      wr(6'h1d, t ? 8'h05 : 8'h01, r);
      wr(6'h01, 8'h03, r);
      p = drive_polarity;
      while (drive_polarity === p) @(posedge aclk);
      p = drive_polarity;
      pl = input_trigger_pin;
      n = 0;
      v = 0;
      // First interval may be partial, so count over the second one
      while (drive_polarity === p) begin
        @(posedge aclk);
        n += int'(input_trigger_pin && !pl);
        v += int'(backemf_sample);
        pl = input_trigger_pin;
      end
      chk(n, 64);
      // One sample per drive period, or one per half period when twice is set
      chk(v, t ? 1 : int'(!p));
    end
    $display("open loop test done");
    wr(6'h20, 8'h01, r);
    wr(6'h1d, 8'h01, r);
    wr(6'h01, 8'h05, r);
    for (int t = 0; t < 2; t++) begin
      p = drive_polarity;
      n = 0;
      while (drive_polarity === p) begin
        @(posedge aclk);
        n++;
      end
    end
    // One period unit of 98.49 us at 40 ns a cycle, half of it per polarity
    chk(n, 98490 / 40 / 2);
    $display("digital open loop test done");
    wrap_up();
  end
endmodule
bind hlc_top hlc_props props (.*);
